// ### hdl/esl_pkg.sv
package esl_pkg;
	localparam logic [7:0] ESL_ERR_STATUS_OFS = 8'hc8;
	localparam int ESL_W = 16;
	localparam logic [15:0] ESL_RESET_VAL = 16'h0000;
	localparam int ESL_BIT_GFX = 12;
	localparam int ESL_BIT_THERM = 11;
	localparam int ESL_BIT_LOCK = 9;
	localparam int ESL_BIT_REFR = 8;
	localparam int ESL_BIT_THROT = 7;
	// Bits that hold a flag; all others read zero
	localparam logic [15:0] ESL_IMPL_MASK = 16'h1b80;
	// Bits that may raise an upstream error message
	localparam logic [15:0] ESL_SERR_MASK = 16'h0b80;
	localparam int ESL_REFR_CW = 11;
	localparam logic [10:0] ESL_REFR_LIMIT = 11'h400;
	localparam logic [10:0] ESL_REFR_ZERO = 11'h000;
	localparam logic [10:0] ESL_REFR_ONE = 11'h001;
endpackage

// ### hdl/esl_flag_cell.sv
`timescale 1ns/1ps
// One sticky flag, write one to clear, set wins over clear
module esl_flag_cell
	import esl_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic set_i,
	input wire logic clr_i,
	output logic flag_o
);
	logic flag_d;
	logic flag_q;

	always_comb begin
		flag_d = (flag_q & ~clr_i) | set_i;
	end

	// Only cold reset clears; warm reset never reaches here
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	assign flag_o = flag_q;
endmodule // esl_flag_cell

// ### hdl/esl_refresh_queue.sv
`timescale 1ns/1ps
// Counts refreshes waiting and pulses when the count reaches the limit
module esl_refresh_queue
	import esl_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic enq_i,
	input wire logic deq_i,
	output logic hit_o
);
	logic [ESL_REFR_CW-1:0] cnt_d;
	logic [ESL_REFR_CW-1:0] cnt_q;

	// Saturate at the limit so the count never wraps back to zero
	always_comb begin
		cnt_d = cnt_q;
		if (enq_i && !deq_i && cnt_q != ESL_REFR_LIMIT) begin
			cnt_d = cnt_q + ESL_REFR_ONE;
		end else if (deq_i && !enq_i && cnt_q != ESL_REFR_ZERO) begin
			cnt_d = cnt_q - ESL_REFR_ONE;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			cnt_q <= ESL_REFR_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign hit_o = (cnt_d == ESL_REFR_LIMIT) && (cnt_q != ESL_REFR_LIMIT);
endmodule // esl_refresh_queue

// ### hdl/esl_logger.sv
`timescale 1ns/1ps
// Error status logger: sticky flags, upstream error requests, thermal gate
module esl_logger
	import esl_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic warm_rst_i,
	// Configuration access
	input wire logic cfg_wr_i,
	input wire logic cfg_rd_i,
	input wire logic [7:0] cfg_addr_i,
	input wire logic [1:0] cfg_be_i,
	input wire logic [15:0] cfg_wdata_i,
	output logic [15:0] cfg_rdata_o,
	output logic cfg_rvalid_o,
	// Enables held in neighbouring blocks
	input wire logic [15:0] error_command_i,
	input wire logic bridge_serr_en_i,
	input wire logic smi_therm_en_i,
	input wire logic sci_therm_en_i,
	// Lock sources
	input wire logic trusted_mode_i,
	input wire logic mgmt_mode_i,
	input wire logic memory_lockdown_bit_i,
	// Event sources
	input wire logic gfx_sw_smi_i,
	input wire logic thermal_trip_i,
	input wire logic lock_nondram_i,
	input wire logic refresh_enq_i,
	input wire logic refresh_deq_i,
	input wire logic throttle_i,
	// Messages out
	output logic serr_req_o,
	input wire logic serr_ack_i,
	output logic thermal_smi_o,
	output logic thermal_sci_o
);

	////////////////////////////////////////////////////////////////////////
	// Event decode

	logic refr_hit;
	logic locked;
	logic hit;
	logic serr_therm;
	logic therm_send;
	logic [15:0] flags;
	logic [15:0] set_vec;
	logic [15:0] clr_vec;
	logic [15:0] serr_rise;

	esl_refresh_queue u_refr (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.enq_i(refresh_enq_i),
		.deq_i(refresh_deq_i),
		.hit_o(refr_hit)
	);

	assign locked = trusted_mode_i | mgmt_mode_i | memory_lockdown_bit_i;
	assign hit = cfg_wr_i && (cfg_addr_i == ESL_ERR_STATUS_OFS);

	// global gate on the thermal error path
	assign serr_therm = error_command_i[ESL_BIT_THERM] & bridge_serr_en_i;
	assign therm_send = thermal_trip_i & ~flags[ESL_BIT_THERM] &
		(serr_therm | smi_therm_en_i | sci_therm_en_i);

	// Set sources; is the software side, not checked here
	always_comb begin
		set_vec = 16'h0000;
		set_vec[ESL_BIT_GFX] = gfx_sw_smi_i;
		set_vec[ESL_BIT_THERM] = therm_send;
		set_vec[ESL_BIT_LOCK] = lock_nondram_i;
		set_vec[ESL_BIT_REFR] = refr_hit;
		set_vec[ESL_BIT_THROT] = throttle_i;
	end

	always_comb begin
		clr_vec = 16'h0000;
		if (hit && !locked) begin
			clr_vec[7:0] = cfg_be_i[0] ? cfg_wdata_i[7:0] : 8'h00;
			clr_vec[15:8] = cfg_be_i[1] ? cfg_wdata_i[15:8] : 8'h00;
		end
		clr_vec = clr_vec & ESL_IMPL_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	// Flag storage

	genvar gi;
	generate
		for (gi = 0; gi < ESL_W; gi++) begin : g_flag
			if (ESL_IMPL_MASK[gi]) begin : g_impl
				esl_flag_cell u_cell (
					.core_clk_i(core_clk_i),
					.rst_i(rst_i),
					.set_i(set_vec[gi]),
					.clr_i(clr_vec[gi]),
					.flag_o(flags[gi])
				);
			end else begin : g_rsv
				assign flags[gi] = 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Upstream error request

	logic serr_d;
	logic serr_q;

	assign serr_rise = set_vec & ~flags & ESL_SERR_MASK & error_command_i &
		{16{bridge_serr_en_i}};

	// Request held until the link takes it; new rises merge into it
	always_comb begin
		serr_d = serr_q;
		if (serr_ack_i) begin
			serr_d = 1'b0;
		end
		if (|serr_rise) begin
			serr_d = 1'b1;
		end
	end

	// Warm reset drops a pending message but keeps the flags
	always_ff @(posedge core_clk_i) begin
		if (rst_i || warm_rst_i) begin
			serr_q <= 1'b0;
		end else begin
			serr_q <= serr_d;
		end
	end

	assign serr_req_o = serr_q;

	////////////////////////////////////////////////////////////////////////
	// Thermal management and control interrupt pulses

	logic smi_d;
	logic smi_q;
	logic sci_d;
	logic sci_q;

	always_comb begin
		smi_d = therm_send & smi_therm_en_i;
		sci_d = therm_send & sci_therm_en_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			smi_q <= 1'b0;
			sci_q <= 1'b0;
		end else begin
			smi_q <= smi_d;
			sci_q <= sci_d;
		end
	end

	assign thermal_smi_o = smi_q;
	assign thermal_sci_o = sci_q;

	////////////////////////////////////////////////////////////////////////
	// Read path

	logic [15:0] rdata_d;
	logic [15:0] rdata_q;
	logic rvalid_d;
	logic rvalid_q;

	// Unmapped offsets read zero rather than stale data
	always_comb begin
		rvalid_d = cfg_rd_i;
		rdata_d = rdata_q;
		if (cfg_rd_i) begin
			rdata_d = (cfg_addr_i == ESL_ERR_STATUS_OFS) ?
				(flags & ESL_IMPL_MASK) : 16'h0000;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			rdata_q <= ESL_RESET_VAL;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end

	assign cfg_rdata_o = rdata_q;
	assign cfg_rvalid_o = rvalid_q;

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);

	chk_serr_on_rise: assert property (
		(|serr_rise) && !warm_rst_i |=> serr_req_o)
		else $error("error request missing after enabled flag rise");

	chk_serr_no_cause: assert property (
		!serr_req_o && !(|serr_rise) |=> !serr_req_o)
		else $error("error request without an enabled rise");

	chk_serr_lock_dis: assert property (
		!serr_req_o && lock_nondram_i && !error_command_i[ESL_BIT_LOCK] &&
		!(|(set_vec & ~ESL_SERR_MASK)) && set_vec == 16'h0200
		|=> !serr_req_o)
		else $error("error request despite disabled enable");

	chk_flag_always: assert property (
		lock_nondram_i |=> flags[ESL_BIT_LOCK])
		else $error("lock flag not set");

	chk_w1c_clear: assert property (
		hit && !locked && cfg_be_i[0] && cfg_wdata_i[ESL_BIT_THROT] &&
		!throttle_i |=> !flags[ESL_BIT_THROT])
		else $error("throttle flag not cleared by write of one");

	chk_lock_hold: assert property (
		locked |=> ($past(flags) & ~flags) == 16'h0000)
		else $error("flag cleared while locked");

	chk_gfx_flag: assert property (
		gfx_sw_smi_i |=> flags[ESL_BIT_GFX])
		else $error("graphics event flag not set");

	chk_therm_nosend: assert property (
		!flags[ESL_BIT_THERM] && !smi_therm_en_i && !sci_therm_en_i &&
		!serr_therm |=> !flags[ESL_BIT_THERM])
		else $error("thermal flag set without a message");

	chk_therm_block: assert property (
		flags[ESL_BIT_THERM] |=> !thermal_smi_o && !thermal_sci_o)
		else $error("thermal message while flag already set");

	chk_refresh_flag: assert property (
		refr_hit |=> flags[ESL_BIT_REFR])
		else $error("refresh timeout flag not set");

	chk_rsv_zero: assert property (
		cfg_rvalid_o |-> (cfg_rdata_o & ~ESL_IMPL_MASK) == 16'h0000)
		else $error("reserved bits read nonzero");

	chk_throt_wins: assert property (
		throttle_i && clr_vec[ESL_BIT_THROT] |=> flags[ESL_BIT_THROT])
		else $error("throttle flag lost to a clear");

	chk_throt_read: assert property (
		cfg_rd_i && cfg_addr_i == ESL_ERR_STATUS_OFS |=>
		cfg_rdata_o[ESL_BIT_THROT] == $past(flags[ESL_BIT_THROT]))
		else $error("throttle flag read wrong");

	chk_warm_keep: assert property (
		warm_rst_i && !(|clr_vec) |=>
		($past(flags) & ~flags) == 16'h0000)
		else $error("flag lost over warm reset");

	chk_serr_ack: assert property (
		serr_req_o && serr_ack_i && !(|serr_rise) |=> !serr_req_o)
		else $error("error request held after ack");

	chk_therm_send: assert property (
		thermal_trip_i && !flags[ESL_BIT_THERM] && smi_therm_en_i |=>
		flags[ESL_BIT_THERM] && thermal_smi_o)
		else $error("thermal trip with message path lost");

	cov_serr_sent: cover property (|serr_rise ##1 serr_req_o ##[1:4] serr_ack_i);
	cov_warm_keep: cover property (warm_rst_i && (|flags));
	cov_therm_smi: cover property (thermal_trip_i ##1 thermal_smi_o);
	cov_locked_wr: cover property (hit && locked);
	cov_clear_read: cover property (hit ##1 cfg_rd_i ##1 cfg_rvalid_o);

endmodule // esl_logger

// ### test/esl_link_model.sv
`timescale 1ns/1ps
// Far end of the upstream link: takes error messages, acks after a lag
module esl_link_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic serr_req_i,
	input wire logic [3:0] lag_i,
	output logic serr_ack_o,
	output int msgs_o
);
	logic [3:0] wait_q;
	////////////////////////////////////////////////////////////////////////
	// count received messages
	// Ack is a one-cycle pulse; no ack while one is still on the wire
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			wait_q <= 4'h0;
			serr_ack_o <= 1'b0;
			msgs_o <= 0;
		end else begin
			serr_ack_o <= 1'b0;
			if (serr_req_i && !serr_ack_o) begin
				if (wait_q == lag_i) begin
					serr_ack_o <= 1'b1;
					wait_q <= 4'h0;
					msgs_o <= msgs_o + 1;
				end else begin
					wait_q <= wait_q + 4'h1;
				end
			end
		end
	end
endmodule // esl_link_model

// ### test/test_error_status_serr_logger.sv
`timescale 1ns/1ps
// Bench for the error status logger
module test_error_status_serr_logger;
	import esl_pkg::*;
	logic clk = 0, rst = 1, warm = 0, wr = 0, rd = 0, gen = 0;
	logic smie = 0, scie = 0, deq = 0;
	logic [7:0] addr = 8'h00;
	logic [1:0] be = 2'b00;
	logic [15:0] wd = 16'h0000, ecmd = 16'h0000, rdata;
	logic [2:0] lks = 3'b000;
	logic [4:0] evt = 5'b00000;
	logic [3:0] lag = 4'h0;
	logic rvalid, req, ack, tsmi, tsci;
	int msgs, num_errors = 0, tests_run = 0;
	always #2.5 clk = ~clk;
	esl_logger esl_logger_i (.core_clk_i(clk), .rst_i(rst),
		.warm_rst_i(warm), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr),
		.cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdata),
		.cfg_rvalid_o(rvalid), .error_command_i(ecmd),
		.bridge_serr_en_i(gen), .smi_therm_en_i(smie),
		.sci_therm_en_i(scie), .trusted_mode_i(lks[0]),
		.mgmt_mode_i(lks[1]), .memory_lockdown_bit_i(lks[2]),
		.gfx_sw_smi_i(evt[0]), .thermal_trip_i(evt[1]),
		.lock_nondram_i(evt[2]), .refresh_enq_i(evt[3]),
		.refresh_deq_i(deq), .throttle_i(evt[4]), .serr_req_o(req),
		.serr_ack_i(ack), .thermal_smi_o(tsmi), .thermal_sci_o(tsci));
	esl_link_model esl_link_model_i (.core_clk_i(clk), .rst_i(rst),
		.serr_req_i(req), .lag_i(lag), .serr_ack_o(ack), .msgs_o(msgs));
	////////////////////////////////////////////////////////////////////////
	// Shared tasks; inputs move 1 ns after the rising edge
	task tick;
		@(posedge clk);
		#1;
	endtask
	task chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wr16(input logic [7:0] a, input logic [15:0] d);
		addr = a;
		wd = d;
		be = 2'b11;
		wr = 1;
		tick;
		wr = 0;
		tick;
	endtask
	task rd_chk(input logic [7:0] a, input logic [15:0] e);
		addr = a;
		rd = 1;
		tick;
		rd = 0;
		chk(16'(rvalid), 16'h0001);
		chk(rdata, e);
		tick;
	endtask
	// Event pulse, then wait for any message to be acked
	task ev(input int k);
		evt[k] = 1;
		tick;
		evt[k] = 0;
		for (int i = 0; i < 20 && req !== 1'b0; i++) tick;
	endtask
	task done(input string n);
		$display("test %s done", n);
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run is about 1130 cycles; far below this limit
	initial begin
		#50000;
		num_errors++;
		end_sim;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) tick;
		rst = 0;
		rd_chk(8'hc8, 16'h0000);
		rd_chk(8'hc4, 16'h0000);
		done("reset");
		ecmd = 16'h0b80;
		gen = 1;
		ev(2);
		rd_chk(8'hc8, 16'h0200);
		rd_chk(8'hca, 16'h0000);
		chk(16'(msgs), 16'h0001);
		ev(2);
		chk(16'(msgs), 16'h0001);
		done("lock flag");
		// Each lock source alone must refuse the clear
		for (int k = 0; k < 3; k++) begin
			lks = 3'(1 << k);
			wr16(8'hc8, 16'hffff);
			rd_chk(8'hc8, 16'h0200);
		end
		lks = 3'b000;
		wr16(8'hc8, 16'h0000);
		rd_chk(8'hc8, 16'h0200);
		wr16(8'hc8, 16'hffff);
		rd_chk(8'hc8, 16'h0000);
		ev(2);
		chk(16'(msgs), 16'h0002);
		wr16(8'hc8, 16'hffff);
		done("write lock");
		gen = 0;
		ev(0);
		ev(4);
		rd_chk(8'hc8, 16'h1080);
		chk(16'(msgs), 16'h0002);
		warm = 1;
		tick;
		warm = 0;
		rd_chk(8'hc8, 16'h1080);
		// Low byte lane only: bit 12 must survive
		addr = 8'hc8;
		wd = 16'hffff;
		be = 2'b01;
		wr = 1;
		tick;
		wr = 0;
		rd_chk(8'hc8, 16'h1000);
		wr16(8'hc8, 16'hffff);
		gen = 1;
		ecmd = 16'h0900;
		ev(4);
		ev(2);
		rd_chk(8'hc8, 16'h0280);
		chk(16'(msgs), 16'h0002);
		wr16(8'hc8, 16'hffff);
		rd_chk(8'hc8, 16'h0000);
		// Throttle and clear on one edge: the set must win
		evt[4] = 1;
		addr = 8'hc8;
		wd = 16'hffff;
		be = 2'b11;
		wr = 1;
		tick;
		evt[4] = 0;
		wr = 0;
		rd_chk(8'hc8, 16'h0080);
		wr16(8'hc8, 16'hffff);
		done("gates");
		ecmd = 16'h0000;
		smie = 1;
		evt[1] = 1;
		tick;
		chk(16'(tsmi), 16'h0001);
		evt[1] = 0;
		tick;
		chk(16'(tsmi), 16'h0000);
		rd_chk(8'hc8, 16'h0800);
		evt[1] = 1;
		tick;
		chk(16'(tsmi), 16'h0000);
		evt[1] = 0;
		wr16(8'hc8, 16'hffff);
		smie = 0;
		scie = 1;
		evt[1] = 1;
		tick;
		chk(16'(tsci), 16'h0001);
		evt[1] = 0;
		wr16(8'hc8, 16'hffff);
		scie = 0;
		ev(1);
		rd_chk(8'hc8, 16'h0000);
		ecmd = 16'h0800;
		lag = 4'h3;
		ev(1);
		rd_chk(8'hc8, 16'h0800);
		chk(16'(msgs), 16'h0003);
		wr16(8'hc8, 16'hffff);
		done("thermal");
		ecmd = 16'h0100;
		evt[3] = 1;
		repeat (1023) tick;
		evt[3] = 0;
		deq = 1;
		tick;
		deq = 0;
		ev(3);
		rd_chk(8'hc8, 16'h0000);
		ev(3);
		rd_chk(8'hc8, 16'h0100);
		chk(16'(msgs), 16'h0004);
		done("refresh");
		end_sim;
	end
endmodule // test_error_status_serr_logger
